// [hw/snoop_atomic_guard.sv]
// snoop_atomic_guard: snoop initiation/response and atomic-sequence guard
// assumes a tag array answers lookup_state_in in the cycle after tag_lookup_out
`timescale 1ns/1ps

module snoop_atomic_guard #(
  parameter int unsigned ADDR_W     = snoop_guard_pkg::ADDR_W,
  parameter int unsigned LINE_OFS_W = snoop_guard_pkg::LINE_OFS_W
) (
  input  wire logic              mclk_in,                     // main clock
  input  wire logic              arst_n_in,                   // async reset, active low
  input  wire logic              strobe_async_in,             // high: strobe is async, use synchronised copy
  input  wire logic              snoop_request_strobe_n_in,   // snoop strobe, low active
  input  wire logic [ADDR_W-1:0] snoop_addr_in,               // snoop address
  input  wire logic              snoop_invalidate_attr_in,    // snoop invalidate attribute
  input  wire logic              snoop_noncacheable_attr_in,  // snoop noncacheable attribute
  input  wire logic [1:0]        lookup_state_in,             // tag answer for lookup
  input  wire logic              backinv_active_in,           // back-invalidation running
  input  wire logic              snoop_wb_done_in,            // snoop write-back finished
  input  wire logic              cpu_read_req_in,             // processor read request
  input  wire logic              cpu_address_strobe_n_in,     // processor cycle start, low
  input  wire logic [ADDR_W-1:0] cpu_addr_in,                 // processor address
  input  wire logic              cpu_atomic_n_in,             // atomic sequence, low active
  input  wire logic              cpu_split_cycle_in,          // split atomic cycle
  input  wire logic              cpu_write_in,                // processor cycle is a write
  input  wire logic              cpu_hit_in,                  // processor lookup hit
  input  wire logic              cpu_hit_em_in,               // hit to E or M line
  input  wire logic              victim_modified_in,          // fill replaces a modified line
  input  wire logic              inquire_done_in,             // inquire to processor done
  input  wire logic              wb_done_in,                  // replacement write-back done
  input  wire logic              bus_guarantee_n_in,          // bus guarantee, low
  input  wire logic              snoop_window_end_n_in,       // snoop window end, low
  input  wire logic              cacheability_window_end_n_in,// cacheability window end, low
  input  wire logic              cycle_ready_n_in,            // cycle ready, low
  input  wire logic              membus_cacheable_n_in,       // cacheable response, low
  input  wire logic              writeback_or_writethrough_in,// high: exclusive or modified
  output logic                   snoop_lookup_active_n_out,   // snoop cycle, low
  output logic                   snoop_busy_n_out,            // snoop busy, low
  output logic                   snoop_modified_hit_n_out,    // modified hit, low
  output logic                   snoop_any_hit_n_out,         // any hit, low
  output logic                   tag_lookup_out,              // drive tag lookup of snoop
  output logic                   snoop_wb_pending_out,        // snoop write-back scheduled
  output logic                   cpu_read_stall_out,          // processor read waits
  output logic                   membus_address_strobe_n_out, // memory cycle start, low
  output logic                   membus_atomic_flag_n_out,    // atomic indicator, low
  output logic                   line_fill_out,               // atomic read becomes fill
  output logic                   inquire_address_strobe_n_out,// inquire to processor, low
  output logic                   replace_wb_start_out,        // start replacement write-back
  output logic                   atomic_internal_out,         // atomic write served inside
  output logic                   held_locked_address_valid_out // held address valid
);

  localparam int unsigned LW = 2 + ADDR_W;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                          sync1;
    logic                          sync2;
    logic                          strobe_q;
    snoop_guard_pkg::snoop_state_e sn;
    snoop_guard_pkg::mem_phase_e   ph;
    snoop_guard_pkg::atomic_state_e at;
    logic [1:0]                    hold_cnt;
    logic                          pend;
    logic                          cur_idx;
    logic                          wr_idx;
    logic                          guarantee_seen;
    logic                          wb_atomic;
    logic                          lar_valid;
    logic [ADDR_W-1:0]             held_locked_address;
    logic                          cyc_n;
    logic                          busy_n;
    logic                          mhit_n;
    logic                          hit_n;
    logic                          lookup;
    logic                          wb_pend;
    logic                          stall;
    logic                          membus_address_strobe_n;
    logic                          membus_atomic_flag_n;
    logic                          fill;
    logic                          inquire_address_strobe_n;
    logic                          wb_start;
    logic                          internal;
  } state_s;

  state_s r;
  state_s nx;
  logic [LW-1:0] rd_data;
  logic          wr_en;

  function automatic logic same_line(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    same_line = a[ADDR_W-1:LINE_OFS_W] == b[ADDR_W-1:LINE_OFS_W];
  endfunction

  // ---------------------------------------------------------------
  // strobe capture
  // ---------------------------------------------------------------
  logic strobe_lvl;
  logic strobe_rise;
  logic accept;
  logic snoop_ready;
  logic lar_match;
  logic atomic_act;

  assign strobe_lvl  = strobe_async_in ? r.sync2 : !snoop_request_strobe_n_in;
  assign strobe_rise = strobe_lvl && !r.strobe_q;
  // one snoop in flight plus one latched once lookup active was given
  assign accept      = strobe_rise && !r.pend;
  assign wr_en       = accept;
  assign atomic_act  = !cpu_atomic_n_in;
  assign lar_match   = r.lar_valid && r.membus_atomic_flag_n && same_line(rd_data[ADDR_W-1:0], r.held_locked_address);

  snoop_latch #(
    .WIDTH(LW)
  ) u_latch (
    .mclk_in     (mclk_in),
    .arst_n_in   (arst_n_in),
    .wr_en_in    (wr_en),
    .wr_idx_in   (r.wr_idx),
    .wr_data_in  ({snoop_invalidate_attr_in, snoop_noncacheable_attr_in, snoop_addr_in}),
    .rd_idx_in   (r.cur_idx),
    .rd_data_out (rd_data)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nx          = r;
    nx.sync1    = snoop_request_strobe_n_in == 1'b0;
    nx.sync2    = r.sync1;
    nx.strobe_q = strobe_lvl;
    nx.lookup   = 1'b0;
    nx.membus_address_strobe_n   = 1'b1;
    nx.inquire_address_strobe_n   = 1'b1;
    nx.wb_start = 1'b0;
    nx.internal = 1'b0;
    nx.fill     = 1'b0;
    nx.cyc_n    = 1'b1;
    snoop_ready = 1'b0;

    if (accept) begin
      nx.pend   = 1'b1;
      nx.wr_idx = !r.wr_idx;
    end

    // memory cycle phase tracking
    case (r.ph)
      snoop_guard_pkg::PH_IDLE: begin
        if (!r.membus_address_strobe_n) begin
          nx.ph = snoop_guard_pkg::PH_STARTED;
        end
      end
      snoop_guard_pkg::PH_STARTED: begin
        // guarantee ignored while lookup active, answer pending or modified-hit busy
        if (!bus_guarantee_n_in && r.cyc_n && r.sn != snoop_guard_pkg::SN_RESP
            && !(!r.busy_n && !r.mhit_n)) begin
          nx.ph = snoop_guard_pkg::PH_GUARANTEED;
        end
      end
      snoop_guard_pkg::PH_GUARANTEED: begin
        if (!snoop_window_end_n_in) begin
          nx.ph       = snoop_guard_pkg::PH_SNOOPWIN;
          nx.hold_cnt = snoop_guard_pkg::HOLD_CNT_INIT;
        end
      end
      snoop_guard_pkg::PH_SNOOPWIN: begin
        if (!cycle_ready_n_in) begin
          nx.ph = snoop_guard_pkg::PH_IDLE;
        end
      end
      default: nx.ph = snoop_guard_pkg::PH_IDLE;
    endcase
    // count runs on even when the cycle completes right after window end
    if (r.ph != snoop_guard_pkg::PH_GUARANTEED && r.hold_cnt != 2'h0) begin
      nx.hold_cnt = r.hold_cnt - 2'h1;
    end

    // write-back waits for the cycle to finish; a new modified hit below wins
    if (r.wb_pend && r.ph == snoop_guard_pkg::PH_IDLE && snoop_wb_done_in) begin
      nx.wb_pend = 1'b0;
    end

    // snoop engine
    case (r.sn)
      snoop_guard_pkg::SN_IDLE: begin
        if (r.pend) begin
          nx.sn = snoop_guard_pkg::SN_WAIT;
        end
      end
      snoop_guard_pkg::SN_WAIT: begin
        // latched data now readable; guarantee phase holds it back
        if (r.ph == snoop_guard_pkg::PH_GUARANTEED) begin
          nx.sn = snoop_guard_pkg::SN_HOLD;
        end else if (lar_match && atomic_act) begin
          nx.busy_n = 1'b0;
        end else if (r.busy_n || !r.wb_pend) begin
          snoop_ready = 1'b1;
        end
      end
      snoop_guard_pkg::SN_HOLD: begin
        if (r.ph != snoop_guard_pkg::PH_GUARANTEED && r.hold_cnt == 2'h1) begin
          snoop_ready = 1'b1;
        end
      end
      snoop_guard_pkg::SN_LOOKUP: begin
        // tag array answers in the following cycle
        nx.sn = snoop_guard_pkg::SN_RESP;
      end
      snoop_guard_pkg::SN_RESP: begin
        // responses valid two clocks after lookup active
        nx.mhit_n = !(lookup_state_in == snoop_guard_pkg::LINE_M);
        nx.hit_n  = lookup_state_in == snoop_guard_pkg::LINE_I;
        if (lookup_state_in == snoop_guard_pkg::LINE_M || backinv_active_in) begin
          nx.busy_n = 1'b0;
        end
        if (lookup_state_in == snoop_guard_pkg::LINE_M) begin
          nx.wb_pend = 1'b1;
        end
        nx.sn = snoop_guard_pkg::SN_BUSY;
      end
      snoop_guard_pkg::SN_BUSY: begin
        if (!r.wb_pend && !backinv_active_in) begin
          nx.busy_n = 1'b1;
          nx.mhit_n = 1'b1;
          nx.hit_n  = 1'b1;
          nx.sn     = snoop_guard_pkg::SN_IDLE;
        end
      end
      default: nx.sn = snoop_guard_pkg::SN_IDLE;
    endcase

    if (snoop_ready) begin
      nx.cyc_n   = 1'b0;
      nx.lookup  = 1'b1;
      nx.pend    = accept;
      nx.cur_idx = !r.cur_idx;
      nx.busy_n  = 1'b1;
      nx.sn      = snoop_guard_pkg::SN_LOOKUP;
    end
    if (r.busy_n == 1'b0 && r.sn == snoop_guard_pkg::SN_WAIT && !atomic_act) begin
      nx.busy_n = 1'b1;
    end

    // snoop beats processor read
    nx.stall = cpu_read_req_in && (r.pend || snoop_ready);

    // atomic sequence
    case (r.at)
      snoop_guard_pkg::AT_IDLE: begin
        if (!cpu_address_strobe_n_in && atomic_act && !nx.stall) begin
          if (!cpu_write_in && !cpu_split_cycle_in) begin
            nx.held_locked_address       = cpu_addr_in;
            nx.lar_valid = 1'b1;
          end
          if (cpu_write_in && cpu_hit_em_in) begin
            nx.internal = 1'b1;
          end else if (!cpu_hit_in || cpu_split_cycle_in) begin
            nx.membus_address_strobe_n  = 1'b0;
            nx.membus_atomic_flag_n = 1'b0;
            nx.at      = snoop_guard_pkg::AT_MISS_CYC;
          end
        end
      end
      snoop_guard_pkg::AT_MISS_CYC: begin
        if (!cacheability_window_end_n_in) begin
          if (!membus_cacheable_n_in && !cpu_split_cycle_in) begin
            nx.fill      = 1'b1;
            nx.wb_atomic = 1'b1;
            if (victim_modified_in) begin
              nx.inquire_address_strobe_n   = 1'b0;
              nx.wb_start = 1'b1;
              nx.at       = snoop_guard_pkg::AT_WB;
            end
          end else begin
            nx.at = snoop_guard_pkg::AT_HELD;
          end
        end
      end
      snoop_guard_pkg::AT_WB: begin
        if (wb_done_in && inquire_done_in) begin
          nx.at = snoop_guard_pkg::AT_HELD;
        end
      end
      snoop_guard_pkg::AT_HELD: begin
        if (!cpu_address_strobe_n_in && cpu_write_in && cpu_hit_em_in) begin
          nx.internal = 1'b1;
        end
      end
      default: nx.at = snoop_guard_pkg::AT_IDLE;
    endcase
    if (r.at != snoop_guard_pkg::AT_IDLE && !snoop_window_end_n_in
        && writeback_or_writethrough_in) begin
      nx.membus_atomic_flag_n   = 1'b1;
      nx.wb_atomic = 1'b0;
    end
    if (r.wb_start && !r.wb_atomic) begin
      nx.membus_atomic_flag_n = 1'b1;
    end
    if (!atomic_act && r.at != snoop_guard_pkg::AT_IDLE) begin
      nx.lar_valid = 1'b0;
      nx.membus_atomic_flag_n   = 1'b1;
      nx.at        = snoop_guard_pkg::AT_IDLE;
    end
    if (!atomic_act && r.lar_valid) begin
      nx.lar_valid = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registers and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r          <= '0;
      r.sn       <= snoop_guard_pkg::SN_IDLE;
      r.ph       <= snoop_guard_pkg::PH_IDLE;
      r.at       <= snoop_guard_pkg::AT_IDLE;
      r.cyc_n    <= 1'b1;
      r.busy_n   <= 1'b1;
      r.mhit_n   <= 1'b1;
      r.hit_n    <= 1'b1;
      r.membus_address_strobe_n   <= 1'b1;
      r.membus_atomic_flag_n  <= 1'b1;
      r.inquire_address_strobe_n   <= 1'b1;
    end else begin
      r <= nx;
    end
  end

  assign snoop_lookup_active_n_out     = r.cyc_n;
  assign snoop_busy_n_out              = r.busy_n;
  assign snoop_modified_hit_n_out      = r.mhit_n;
  assign snoop_any_hit_n_out           = r.hit_n;
  assign tag_lookup_out                = r.lookup;
  assign snoop_wb_pending_out          = r.wb_pend;
  assign cpu_read_stall_out            = r.stall;
  assign membus_address_strobe_n_out   = r.membus_address_strobe_n;
  assign membus_atomic_flag_n_out      = r.membus_atomic_flag_n;
  assign line_fill_out                 = r.fill;
  assign inquire_address_strobe_n_out  = r.inquire_address_strobe_n;
  assign replace_wb_start_out          = r.wb_start;
  assign atomic_internal_out           = r.internal;
  assign held_locked_address_valid_out = r.lar_valid;

endmodule

// [hw/snoop_guard_pkg.sv]
// snoop_guard_pkg: constants and types for the snoop and atomic-sequence guard
// assumes one 10 MHz clock; all other blocks import nothing, use pkg::name
package snoop_guard_pkg;

  // ---------------------------------------------------------------
  // widths and timing
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W          = 32;
  localparam int unsigned LINE_OFS_W      = 5;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned HOLD_LOOKUP_CLK = 2;    // clocks from window end to lookup
  localparam int unsigned RESP_DELAY_CLK  = 1;    // clocks from lookup to tag answer
  localparam logic [1:0]  HOLD_CNT_INIT   = 2'h2;

  // ---------------------------------------------------------------
  // line states reported by the tag array
  // ---------------------------------------------------------------
  localparam logic [1:0] LINE_I = 2'h0;
  localparam logic [1:0] LINE_S = 2'h1;
  localparam logic [1:0] LINE_E = 2'h2;
  localparam logic [1:0] LINE_M = 2'h3;

  // ---------------------------------------------------------------
  // phase of the current memory bus cycle
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_STARTED,
    PH_GUARANTEED,
    PH_SNOOPWIN
  } mem_phase_e;

  // snoop engine states
  typedef enum logic [2:0] {
    SN_IDLE,
    SN_HOLD,
    SN_WAIT,
    SN_LOOKUP,
    SN_RESP,
    SN_BUSY
  } snoop_state_e;

  // atomic sequence states
  typedef enum logic [2:0] {
    AT_IDLE,
    AT_MISS_CYC,
    AT_WB,
    AT_HELD,
    AT_INTERNAL
  } atomic_state_e;

endpackage

// [hw/snoop_latch.sv]
// snoop_latch: two-entry snoop address and attribute store
// assumes writes and reads are in the main clock domain
`timescale 1ns/1ps

module snoop_latch #(
  parameter int unsigned WIDTH = 34
) (
  input  wire logic             mclk_in,    // main clock
  input  wire logic             arst_n_in,  // async reset, active low
  input  wire logic             wr_en_in,   // store a new entry
  input  wire logic             wr_idx_in,  // entry to store
  input  wire logic [WIDTH-1:0] wr_data_in, // address and attributes
  input  wire logic             rd_idx_in,  // entry to read
  output logic      [WIDTH-1:0] rd_data_out // registered read data
);

  logic [WIDTH-1:0] mem [2];

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mem[0]      <= '0;
      mem[1]      <= '0;
      rd_data_out <= '0;
    end else begin
      if (wr_en_in) begin
        mem[wr_idx_in] <= wr_data_in;
      end
      rd_data_out <= (wr_en_in && wr_idx_in == rd_idx_in) ? wr_data_in : mem[rd_idx_in];
    end
  end

endmodule

// [tb/snoop_guard_sva.sv]
// snoop_guard_sva: port-level checks of the snoop and atomic guard
// assumes it is bound to snoop_atomic_guard and sees only its ports
`timescale 1ns/1ps

module snoop_guard_sva (
  input wire logic       mclk_in,                       // main clock
  input wire logic       arst_n_in,                     // reset, low
  input wire logic       cpu_atomic_n_in,               // atomic sequence, low
  input wire logic       snoop_window_end_n_in,         // window end, low
  input wire logic       writeback_or_writethrough_in,  // high: E or M
  input wire logic [1:0] lookup_state_in,               // tag answer
  input wire logic       snoop_lookup_active_n_out,     // lookup active, low
  input wire logic       snoop_busy_n_out,              // busy, low
  input wire logic       snoop_modified_hit_n_out,      // modified hit, low
  input wire logic       snoop_any_hit_n_out,           // any hit, low
  input wire logic       tag_lookup_out,                // tag lookup pulse
  input wire logic       membus_address_strobe_n_out,   // memory cycle start, low
  input wire logic       membus_atomic_flag_n_out,      // atomic flag, low
  input wire logic       atomic_internal_out,           // atomic write inside
  input wire logic       held_locked_address_valid_out  // held address valid
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  a_lookup_one_cycle: assert property (
    !snoop_lookup_active_n_out |=> snoop_lookup_active_n_out) else $error("lookup too long");
  a_tag_with_lookup: assert property (
    tag_lookup_out |-> !snoop_lookup_active_n_out) else $error("tag lookup alone");
  a_hit_modified: assert property (
    !snoop_lookup_active_n_out ##1 lookup_state_in == snoop_guard_pkg::LINE_M
    |=> !snoop_modified_hit_n_out && !snoop_any_hit_n_out) else $error("no modified hit");
  a_hit_clean: assert property (
    !snoop_lookup_active_n_out ##1 lookup_state_in inside {2'h1, 2'h2}
    |=> snoop_modified_hit_n_out && !snoop_any_hit_n_out) else $error("bad clean hit");
  a_miss_no_hit: assert property (
    !snoop_lookup_active_n_out ##1 lookup_state_in == snoop_guard_pkg::LINE_I
    |=> snoop_modified_hit_n_out && snoop_any_hit_n_out) else $error("hit on miss");
  a_busy_on_modified: assert property (
    !snoop_lookup_active_n_out ##1 lookup_state_in == snoop_guard_pkg::LINE_M
    |=> !snoop_busy_n_out) else $error("no busy on modified");
  a_atomic_start: assert property (
    $fell(membus_atomic_flag_n_out) |-> !membus_address_strobe_n_out) else $error("flag alone");
  a_flag_drop: assert property (
    !snoop_window_end_n_in && writeback_or_writethrough_in && !membus_atomic_flag_n_out
    |=> membus_atomic_flag_n_out) else $error("atomic flag kept");
  a_valid_clear: assert property (
    cpu_atomic_n_in |=> !held_locked_address_valid_out) else $error("valid not cleared");
  a_internal_no_cycle: assert property (
    atomic_internal_out |-> membus_address_strobe_n_out [*2]) else $error("cycle on internal");
endmodule

bind snoop_atomic_guard snoop_guard_sva snoop_guard_sva_i (.*);

// [tb/membus_partner.sv]
// membus_partner: memory bus controller, tag array and processor inquire side
// assumes the guard's port names; the bench sets line state, hint and wait cycles
`timescale 1ns/1ps

module membus_partner (
  input  wire logic       mclk_in, arst_n_in,                 // clock and reset
  input  wire logic       membus_address_strobe_n_out,        // memory cycle start
  input  wire logic       tag_lookup_out,                     // tag lookup request
  input  wire logic       inquire_address_strobe_n_out,       // inquire request
  input  wire logic       replace_wb_start_out,               // write-back request
  input  wire logic [1:0] line_state_in,                      // state to report
  input  wire logic       wb_hint_in,                         // window end answer
  input  int              wait_cycles_in,                     // slow answer
  output logic      [1:0] lookup_state_in,                    // tag answer
  output logic            inquire_done_in, wb_done_in,        // completions
  output logic            bus_guarantee_n_in, cycle_ready_n_in, // phases
  output logic            cacheability_window_end_n_in,       // phase
  output logic            snoop_window_end_n_in,              // phase
  output logic            membus_cacheable_n_in,              // cacheable answer
  output logic            writeback_or_writethrough_in        // E or M answer
);
  logic [3:0] ph_n;
  logic       inq_p, wb_p;
  int         pend;
  assign {bus_guarantee_n_in, cacheability_window_end_n_in} = ph_n[3:2];
  assign {snoop_window_end_n_in, cycle_ready_n_in} = ph_n[1:0];
  assign membus_cacheable_n_in = ph_n[2];
  // inverse of the answer outside its window end
  assign writeback_or_writethrough_in = ph_n[1] ^ wb_hint_in;
  always @(negedge mclk_in) if (!membus_address_strobe_n_out) pend++;
  always @(posedge mclk_in) begin
    lookup_state_in <= tag_lookup_out ? line_state_in : ~line_state_in;
  end
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {inq_p, wb_p, inquire_done_in, wb_done_in} <= '0;
    end else begin
      inq_p <= !inquire_address_strobe_n_out;
      wb_p <= replace_wb_start_out;
      inquire_done_in <= !inquire_address_strobe_n_out ? 1'b0 : inquire_done_in | inq_p;
      wb_done_in <= replace_wb_start_out ? 1'b0 : wb_done_in | wb_p;
    end
  end
  initial begin
    ph_n = '1;
    pend = 0;
    forever begin
      @(posedge mclk_in);
      if (pend > 0) begin
        pend--;
        repeat (wait_cycles_in) @(posedge mclk_in);
        for (int i = 3; i >= 0; i--) begin
          ph_n[i] <= 1'b0;
          @(posedge mclk_in);
          ph_n[i] <= 1'b1;
        end
      end
    end
  end
endmodule

// [tb/snoop_atomic_guard_tb.sv]
// snoop_atomic_guard_tb: self-checking bench for the snoop and atomic guard
// assumes membus_partner answers the memory bus, tag and inquire sides
`timescale 1ns/1ps

module snoop_atomic_guard_tb;
  logic mclk_in, arst_n_in, strobe_async_in, snoop_request_strobe_n_in;
  logic snoop_invalidate_attr_in, snoop_noncacheable_attr_in, backinv_active_in;
  logic snoop_wb_done_in, cpu_read_req_in, cpu_address_strobe_n_in, cpu_atomic_n_in;
  logic cpu_split_cycle_in, cpu_write_in, cpu_hit_in, cpu_hit_em_in, victim_modified_in;
  logic inquire_done_in, wb_done_in, bus_guarantee_n_in, snoop_window_end_n_in;
  logic cacheability_window_end_n_in, cycle_ready_n_in, membus_cacheable_n_in;
  logic writeback_or_writethrough_in, snoop_lookup_active_n_out, snoop_busy_n_out;
  logic snoop_modified_hit_n_out, snoop_any_hit_n_out, tag_lookup_out, snoop_wb_pending_out;
  logic cpu_read_stall_out, membus_address_strobe_n_out, membus_atomic_flag_n_out;
  logic line_fill_out, inquire_address_strobe_n_out, replace_wb_start_out;
  logic atomic_internal_out, held_locked_address_valid_out, wb_hint_in;
  logic stall_seen, fill_seen, inq_seen;
  logic [31:0] snoop_addr_in, cpu_addr_in;
  logic [1:0]  lookup_state_in, line_state_in;
  logic [1:0]  exp_q[$];
  int          miscompares, compares, wait_cycles_in, n, ns;

  snoop_atomic_guard snoop_atomic_guard_i (.*);
  membus_partner membus_partner_i (.*);

  always #50 mclk_in = ~mclk_in;
  always @(negedge mclk_in) begin
    stall_seen |= (cpu_read_stall_out === 1'b1);
    fill_seen |= (line_fill_out === 1'b1);
    inq_seen |= (inquire_address_strobe_n_out === 1'b0);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wait_lv(ref logic s, input logic v);
    n = 0;
    while (s !== v) begin
      @(negedge mclk_in);
      n++;
      if (n > 300) begin
        miscompares++;
        test_done();
      end
    end
  endtask

  task automatic start(input logic [31:0] a, input logic [1:0] s);
    line_state_in = s;
    exp_q.push_back(s);
    snoop_addr_in = a;
    {snoop_invalidate_attr_in, snoop_noncacheable_attr_in} = 2'($urandom);
    snoop_request_strobe_n_in = 1'b0;
  endtask

  task automatic finish();
    logic [1:0] s;
    wait_lv(snoop_lookup_active_n_out, 1'b0);
    snoop_request_strobe_n_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    s = exp_q.pop_front();
    chk(snoop_modified_hit_n_out, s != snoop_guard_pkg::LINE_M);
    chk(snoop_any_hit_n_out, s == snoop_guard_pkg::LINE_I);
    chk(snoop_busy_n_out, s != snoop_guard_pkg::LINE_M);
    chk(snoop_wb_pending_out, s == snoop_guard_pkg::LINE_M);
  endtask

  initial begin
    void'($urandom(32'hC72B));
    {mclk_in, arst_n_in, strobe_async_in, snoop_invalidate_attr_in} = '0;
    {snoop_noncacheable_attr_in, backinv_active_in, snoop_wb_done_in, cpu_read_req_in} = '0;
    {cpu_split_cycle_in, cpu_write_in, cpu_hit_in, cpu_hit_em_in, victim_modified_in} = '0;
    {wb_hint_in, stall_seen, fill_seen, inq_seen} = '0;
    {snoop_request_strobe_n_in, cpu_address_strobe_n_in, cpu_atomic_n_in} = '1;
    {snoop_addr_in, cpu_addr_in, line_state_in, miscompares, compares, wait_cycles_in} = '0;
    repeat (5) @(negedge mclk_in);
    arst_n_in = 1'b1;
    // -----------------------------------------------------------------
    // every line state, synchronous then synchronised strobe
    // -----------------------------------------------------------------
    for (int i = 0; i < 8; i++) begin
      strobe_async_in = i[2];
      cpu_read_req_in = (i == 1);
      start($urandom, i[1:0]);
      finish();
      cpu_read_req_in = 1'b0;
      if (i == 0) ns = n;
      if (i == 4) chk(n, ns + 2);
      if (i[1:0] == 2'h3) begin
        start($urandom, snoop_guard_pkg::LINE_S);
        repeat (4) begin
          @(negedge mclk_in);
          chk(snoop_lookup_active_n_out, 1'b1);
        end
        snoop_wb_done_in = 1'b1;
        @(negedge mclk_in);
        snoop_wb_done_in = 1'b0;
        finish();
      end
    end
    chk(stall_seen, 1'b1);
    // -----------------------------------------------------------------
    // atomic read miss replacing a modified line, then locked snoop
    // -----------------------------------------------------------------
    {wait_cycles_in, wb_hint_in, strobe_async_in, cpu_addr_in} = {32'h2, 1'b1, 1'b0, 32'h1240};
    {cpu_atomic_n_in, cpu_address_strobe_n_in, victim_modified_in} = 3'h1;
    @(negedge mclk_in);
    cpu_address_strobe_n_in = 1'b1;
    wait_lv(membus_atomic_flag_n_out, 1'b0);
    chk(membus_address_strobe_n_out, 1'b0);
    wait_lv(membus_atomic_flag_n_out, 1'b1);
    chk(held_locked_address_valid_out, 1'b1);
    chk({fill_seen, inq_seen}, 2'h3);
    start(32'h1244, snoop_guard_pkg::LINE_E);
    wait_lv(snoop_busy_n_out, 1'b0);
    {cpu_address_strobe_n_in, cpu_write_in, cpu_hit_in, cpu_hit_em_in} = 4'h7;
    @(negedge mclk_in);
    chk(snoop_lookup_active_n_out, 1'b1);
    cpu_address_strobe_n_in = 1'b1;
    wait_lv(atomic_internal_out, 1'b1);
    cpu_atomic_n_in = 1'b1;
    finish();
    chk(held_locked_address_valid_out, 1'b0);
    test_done();
  end
endmodule
